// ===== verilog/parallel_slave_byte_port.sv
// Parallel slave byte port: register file, strobe handling and data pins
`timescale 1ns/1ps
`default_nettype none
module parallel_slave_byte_port (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// Register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_write,
	input  wire logic       reg_read,
	output var  logic [7:0] reg_rdata,
	// Data pins
	input  wire logic [7:0] data_pin_in,
	output var  logic [7:0] data_pin_out,
	output logic      [7:0] data_pin_oe,
	// Control pins
	input  wire logic [2:0] ctrl_pin_in,
	output var  logic [2:0] ctrl_pin_out,
	output logic      [2:0] ctrl_pin_oe,
	// Interrupt
	output logic            irq
);
	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [7:0] out_latch;
	logic [7:0] in_latch;
	logic [7:0] gpio_in;
	logic [7:0] data_pin_direction;
	logic [2:0] control_pin_direction;
	logic [2:0] ctrl_latch;
	logic [2:0] analog_pin_config;
	logic [7:0] interrupt_control;
	logic [6:0] other_irq_flags;
	logic [6:0] other_irq_enables;
	logic       slave_port_select;
	logic       input_full_flag;
	logic       output_full_flag;
	logic       input_overrun_flag;
	logic       slave_port_irq_flag;
	logic       slave_port_irq_enable;

	// ------------------------------------------------------------
	// Synchronisers and phase counter
	// ------------------------------------------------------------
	logic       rd_n_s;
	logic       wr_n_s;
	logic       cs_n_s;
	logic [7:0] data_s1;
	logic [7:0] data_s2;
	logic [2:0] ctrl_s1;
	logic [2:0] ctrl_s2;
	logic [1:0] phase;

	sync_bit #(.RST_VAL(1'b1)) u_sync_rd (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.async_in (ctrl_pin_in[0]),
		.sync_out (rd_n_s)
	);
	sync_bit #(.RST_VAL(1'b1)) u_sync_wr (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.async_in (ctrl_pin_in[1]),
		.sync_out (wr_n_s)
	);
	sync_bit #(.RST_VAL(1'b1)) u_sync_cs (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.async_in (ctrl_pin_in[2]),
		.sync_out (cs_n_s)
	);

	// Data and gpio pins, plain two-stage capture
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			data_s1 <= 8'h00;
			data_s2 <= 8'h00;
			ctrl_s1 <= 3'h0;
			ctrl_s2 <= 3'h0;
		end else begin
			data_s1 <= data_pin_in;
			data_s2 <= data_s1;
			ctrl_s1 <= ctrl_pin_in;
			ctrl_s2 <= ctrl_s1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			phase <= 2'h0;
		end else begin
			phase <= phase + 2'h1;
		end
	end

	// ------------------------------------------------------------
	// Access detection
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_WAIT2 = 3'b010,
		ST_WAIT4 = 3'b100
	} done_state_t;

	done_state_t wr_state;
	done_state_t rd_state;
	logic        wr_active;
	logic        rd_active;
	logic        wr_done;
	logic        rd_done;
	logic        wr_sel;
	logic        rd_sel;
	logic        cpu_rd_data;
	logic        cpu_wr_data;

	assign wr_sel = slave_port_select && !cs_n_s && !wr_n_s;
	assign rd_sel = slave_port_select && !cs_n_s && !rd_n_s;
	assign cpu_rd_data = reg_read && (reg_addr == psp_pkg::OFF_DATA_LATCH);
	assign cpu_wr_data = reg_write && (reg_addr == psp_pkg::OFF_DATA_LATCH);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_active <= 1'b0;
			in_latch  <= psp_pkg::RST_BYTE;
		end else if (wr_sel) begin
			wr_active <= 1'b1;
			// Byte taken while low; last sample before release wins
			in_latch  <= data_s2;
		end else begin
			wr_active <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rd_active <= 1'b0;
		end else begin
			rd_active <= rd_sel;
		end
	end

	// write completion on phase four after phase two
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_state <= ST_IDLE;
		end else begin
			case (wr_state)
				ST_IDLE:  if (wr_active && !wr_sel) wr_state <= ST_WAIT2;
				ST_WAIT2: if (phase == psp_pkg::PHASE_TWO) wr_state <= ST_WAIT4;
				ST_WAIT4: if (phase == psp_pkg::PHASE_FOUR) wr_state <= ST_IDLE;
				default:  wr_state <= ST_IDLE;
			endcase
		end
	end
	assign wr_done = (wr_state == ST_WAIT4) && (phase == psp_pkg::PHASE_FOUR);

	// read completion on phase four after phase two
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rd_state <= ST_IDLE;
		end else begin
			case (rd_state)
				ST_IDLE:  if (rd_active && !rd_sel) rd_state <= ST_WAIT2;
				ST_WAIT2: if (phase == psp_pkg::PHASE_TWO) rd_state <= ST_WAIT4;
				ST_WAIT4: if (phase == psp_pkg::PHASE_FOUR) rd_state <= ST_IDLE;
				default:  rd_state <= ST_IDLE;
			endcase
		end
	end
	assign rd_done = (rd_state == ST_WAIT4) && (phase == psp_pkg::PHASE_FOUR);

	// ------------------------------------------------------------
	// Status flags
	// ------------------------------------------------------------
	// input full, set wins over the CPU read
	always_ff @(posedge clk) begin
		if (sys_rst || !slave_port_select) begin
			input_full_flag <= 1'b0;
		end else if (wr_done) begin
			input_full_flag <= 1'b1;
		end else if (cpu_rd_data) begin
			input_full_flag <= 1'b0;
		end
	end

	// overrun, sticky until software writes zero
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			input_overrun_flag <= 1'b0;
		end else if (wr_done && input_full_flag && !cpu_rd_data) begin
			input_overrun_flag <= 1'b1;
		end else if (reg_write && reg_addr == psp_pkg::OFF_STATUS_DIR
				&& !reg_wdata[psp_pkg::BIT_OVERRUN]) begin
			input_overrun_flag <= 1'b0;
		end
	end

	// output full, read start clears it at once
	always_ff @(posedge clk) begin
		if (sys_rst || !slave_port_select) begin
			output_full_flag <= 1'b0;
		end else if (rd_sel && !rd_active) begin
			output_full_flag <= 1'b0;
		end else if (cpu_wr_data) begin
			output_full_flag <= 1'b1;
		end
	end

	// irq flag latched on every completion, set wins over clear
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			slave_port_irq_flag <= 1'b0;
		end else if (wr_done || rd_done) begin
			slave_port_irq_flag <= 1'b1;
		end else if (reg_write && reg_addr == psp_pkg::OFF_IRQ_FLAGS
				&& reg_wdata[psp_pkg::BIT_PSP_IRQ]) begin
			slave_port_irq_flag <= 1'b0;
		end
	end

	assign irq = slave_port_irq_flag && slave_port_irq_enable;

	// ------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------
	// CPU writes go to the output latch
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			out_latch <= psp_pkg::RST_BYTE;
		end else if (cpu_wr_data) begin
			out_latch <= reg_wdata;
		end
	end

	// mode and pin configuration, set by software
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			slave_port_select     <= 1'b0;
			control_pin_direction <= psp_pkg::RST_CTRL_DIR;
			data_pin_direction    <= psp_pkg::RST_DATA_DIR;
			analog_pin_config     <= psp_pkg::RST_PIN_CFG;
			ctrl_latch            <= 3'h0;
			interrupt_control     <= psp_pkg::RST_BYTE;
			other_irq_enables     <= 7'h00;
			slave_port_irq_enable <= 1'b0;
			other_irq_flags       <= 7'h00;
		end else if (reg_write) begin
			case (reg_addr)
				psp_pkg::OFF_STATUS_DIR: begin
					slave_port_select     <= reg_wdata[psp_pkg::BIT_SELECT];
					control_pin_direction <= reg_wdata[2:0];
				end
				psp_pkg::OFF_DATA_DIR:    data_pin_direction <= reg_wdata;
				psp_pkg::OFF_PIN_CONFIG:  analog_pin_config  <= reg_wdata[2:0];
				psp_pkg::OFF_CTRL_PORT:   ctrl_latch         <= reg_wdata[2:0];
				psp_pkg::OFF_INT_CTRL:    interrupt_control  <= reg_wdata;
				psp_pkg::OFF_IRQ_ENABLES: begin
					slave_port_irq_enable <= reg_wdata[psp_pkg::BIT_PSP_IRQ];
					other_irq_enables     <= reg_wdata[6:0];
				end
				psp_pkg::OFF_IRQ_FLAGS:   other_irq_flags    <= reg_wdata[6:0];
				default: ;
			endcase
		end
	end

	// Gpio input: data pins registered every cycle, no pin config masking
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			gpio_in <= 8'h00;
		end else begin
			gpio_in <= data_s2;
		end
	end

	// CPU reads of the data latch return the input latch in slave mode
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_read) begin
			case (reg_addr)
				psp_pkg::OFF_DATA_LATCH:  reg_rdata <= slave_port_select ? in_latch : gpio_in;
				psp_pkg::OFF_CTRL_PORT:   reg_rdata <= {5'h00,
					(analog_pin_config == psp_pkg::PIN_CFG_DIGITAL) ? ctrl_s2 : 3'h0};
				psp_pkg::OFF_INT_CTRL:    reg_rdata <= interrupt_control;
				psp_pkg::OFF_IRQ_FLAGS:   reg_rdata <= {slave_port_irq_flag, other_irq_flags};
				psp_pkg::OFF_STATUS_DIR:  reg_rdata <= {input_full_flag, output_full_flag,
					input_overrun_flag, slave_port_select, 1'b0, control_pin_direction};
				psp_pkg::OFF_DATA_DIR:    reg_rdata <= data_pin_direction;
				psp_pkg::OFF_IRQ_ENABLES: reg_rdata <= {slave_port_irq_enable, other_irq_enables};
				psp_pkg::OFF_PIN_CONFIG:  reg_rdata <= {5'h00, analog_pin_config};
				default:                  reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			data_pin_out <= 8'h00;
			ctrl_pin_out <= 3'h0;
		end else begin
			data_pin_out <= out_latch;
			ctrl_pin_out <= ctrl_latch;
		end
	end

	// strobes alone steer the data pins in slave mode
	assign data_pin_oe = slave_port_select ? {8{rd_sel}} : ~data_pin_direction;
	// Control pins stay inputs in slave mode whatever the direction bits
	assign ctrl_pin_oe = slave_port_select ? 3'h0 : ~control_pin_direction;
endmodule : parallel_slave_byte_port
`default_nettype wire

// ===== verilog/psp_pkg.sv
// Constants for the parallel slave byte port
package psp_pkg;
	// Register offsets
	localparam logic [7:0] OFF_DATA_LATCH   = 8'h08;
	localparam logic [7:0] OFF_CTRL_PORT    = 8'h09;
	localparam logic [7:0] OFF_INT_CTRL     = 8'h0b;
	localparam logic [7:0] OFF_IRQ_FLAGS    = 8'h0c;
	localparam logic [7:0] OFF_STATUS_DIR   = 8'h89;
	localparam logic [7:0] OFF_DATA_DIR     = 8'h88;
	localparam logic [7:0] OFF_IRQ_ENABLES  = 8'h8c;
	localparam logic [7:0] OFF_PIN_CONFIG   = 8'h9f;
	// Field positions in slave_port_status_dir
	localparam int BIT_IN_FULL   = 7;
	localparam int BIT_OUT_FULL  = 6;
	localparam int BIT_OVERRUN   = 5;
	localparam int BIT_SELECT    = 4;
	// Slave port irq bit in flags and enables
	localparam int BIT_PSP_IRQ   = 7;
	// Reset values
	localparam logic [2:0] RST_CTRL_DIR  = 3'h7;
	localparam logic [7:0] RST_DATA_DIR  = 8'hff;
	localparam logic [7:0] RST_BYTE      = 8'h00;
	localparam logic [2:0] RST_PIN_CFG   = 3'h0;
	// Pin config value that makes the control pins digital
	localparam logic [2:0] PIN_CFG_DIGITAL = 3'h7;
	// Phase codes of the two-bit phase counter (four core cycles per instruction)
	localparam logic [1:0] PHASE_TWO  = 2'h1;
	localparam logic [1:0] PHASE_FOUR = 2'h3;
	// Synchroniser depth
	localparam int SYNC_STAGES = 2;
endpackage : psp_pkg

// ===== verilog/sync_bit.sv
// Two-stage synchroniser for one asynchronous level
`timescale 1ns/1ps
`default_nettype none
module sync_bit #(
	parameter logic RST_VAL = 1'b1
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic sys_rst,
	// Async in, synchronised out
	input  wire logic async_in,
	output var  logic sync_out
);
	logic meta;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			meta     <= RST_VAL;
			sync_out <= RST_VAL;
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end
endmodule : sync_bit
`default_nettype wire

// ===== verif/ext_master.sv
// Partner model: external byte-wide bus master on the slave port pins
`timescale 1ns/1ps
`default_nettype none
module ext_master (
	// Clock
	input  wire logic       clk,
	// Device pins
	input  wire logic [7:0] data_pin_out,
	input  wire logic [7:0] data_pin_oe,
	output var  logic [7:0] data_pin_in,
	output var  logic [2:0] ctrl_pin_in
);
	logic       drv = 1'b0;
	logic [7:0] val = 8'h00;
	// released bus never shows the last byte
	always_comb data_pin_in = drv ? val : ~val;
	initial ctrl_pin_in = 3'h7;
	// select set by cs_n, write low, data held past release
	task automatic wr(input logic [7:0] d, input logic cs_n);
		@(posedge clk);
		drv <= 1'b1;
		val <= d;
		ctrl_pin_in <= {cs_n, 2'b01};
		repeat (4) @(posedge clk);
		ctrl_pin_in <= 3'h7;
		repeat (2) @(posedge clk);
		drv <= 1'b0;
		repeat (16) @(posedge clk);
	endtask : wr
	// select and read low, byte taken while driven
	task automatic rd(output logic [7:0] d);
		@(posedge clk);
		ctrl_pin_in <= 3'h2;
		repeat (5) @(posedge clk);
		#1;
		d = (data_pin_oe === 8'hff) ? data_pin_out : 8'h00;
		ctrl_pin_in <= 3'h7;
		repeat (16) @(posedge clk);
	endtask : rd
endmodule : ext_master
`default_nettype wire

// ===== verif/parallel_slave_byte_port_chk.sv
// Assertions on the parallel slave byte port
`timescale 1ns/1ps
`default_nettype none
module psp_chk (
	// Clock and reset
	input wire logic       clk,
	input wire logic       sys_rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_write,
	input wire logic       reg_read,
	input wire logic [7:0] reg_rdata,
	// Pins and interrupt
	input wire logic [7:0] data_pin_out,
	input wire logic [7:0] data_pin_oe,
	input wire logic [2:0] ctrl_pin_in,
	input wire logic [2:0] ctrl_pin_oe,
	input wire logic       irq
);
	logic       sel;
	logic [3:0] quiet;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Select as last written by software
	always_ff @(posedge clk) begin
		if (sys_rst)
			sel <= 1'b0;
		else if (reg_write && reg_addr == 8'h89)
			sel <= reg_wdata[4];
	end
	// Idle strobe count; 15 means no completion can be pending
	always_ff @(posedge clk) begin
		if (sys_rst || ctrl_pin_in != 3'h7)
			quiet <= 4'h0;
		else if (quiet != 4'hf)
			quiet <= quiet + 4'h1;
	end
	// ----
	// Checks
	// ----
	select_bit_a: assert property (
		reg_read && reg_addr == 8'h89 |=> reg_rdata[4] == sel) else $error("select bit");
	ctrl_input_a: assert property (
		sel |-> ctrl_pin_oe == 3'h0) else $error("control pins driven");
	read_drive_a: assert property (
		(sel && !ctrl_pin_in[0] && !ctrl_pin_in[2])[*3] |-> data_pin_oe == 8'hff)
		else $error("read not driven");
	rd_release_a: assert property (
		(sel && ctrl_pin_in[0])[*3] |-> data_pin_oe == 8'h00) else $error("pins not freed");
	cs_ignore_a: assert property (
		(sel && ctrl_pin_in[2])[*3] |-> data_pin_oe == 8'h00) else $error("cs ignored");
	out_latch_a: assert property (
		reg_write && reg_addr == 8'h08 ##1 !(reg_write && reg_addr == 8'h08)
		|=> data_pin_out == $past(reg_wdata, 2)) else $error("output latch");
	irq_mask_a: assert property (
		reg_write && reg_addr == 8'h8c && !reg_wdata[7] |=> !irq) else $error("irq mask");
	irq_clear_a: assert property (
		reg_write && reg_addr == 8'h0c && reg_wdata[7] && quiet == 4'hf |=> !irq)
		else $error("irq clear");
	full_idle_a: assert property (
		reg_read && reg_addr == 8'h89 && !sel && !$past(sel) |=> reg_rdata[7:6] == 2'h0)
		else $error("full flags");
	cover property (irq);
	cover property (data_pin_oe == 8'hff);
	cover property (reg_read && reg_addr == 8'h89 ##1 reg_rdata[5]);
endmodule : psp_chk
bind parallel_slave_byte_port psp_chk chk (.clk(clk), .sys_rst(sys_rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
	.reg_read(reg_read), .reg_rdata(reg_rdata), .data_pin_out(data_pin_out),
	.data_pin_oe(data_pin_oe), .ctrl_pin_in(ctrl_pin_in),
	.ctrl_pin_oe(ctrl_pin_oe), .irq(irq));
`default_nettype wire

// ===== verif/parallel_slave_byte_port_bench.sv
// Self-checking bench for the parallel slave byte port
`timescale 1ns/1ps
`default_nettype none
module parallel_slave_byte_port_bench;
	logic       clk = 1'b0;
	logic       sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_write = 1'b0;
	logic       reg_read = 1'b0;
	logic [7:0] reg_rdata, data_pin_out, data_pin_oe, data_pin_in, b;
	logic [2:0] ctrl_pin_in;
	logic [2:0] ctrl_pin_out;
	logic       irq;
	int         fails = 0;
	int         comparisons = 0;
	initial forever #2 clk = ~clk;
	parallel_slave_byte_port dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .data_pin_in(data_pin_in), .data_pin_out(data_pin_out),
		.data_pin_oe(data_pin_oe), .ctrl_pin_in(ctrl_pin_in), .ctrl_pin_out(ctrl_pin_out),
		.ctrl_pin_oe(), .irq(irq));
	ext_master m (.clk(clk), .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe),
		.data_pin_in(data_pin_in), .ctrl_pin_in(ctrl_pin_in));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask : rd
	task automatic end_sim;
		$display("comparisons=%0d fails=%0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim
	// Whole run is near 250 cycles
	initial begin
		#40000;
		fails++;
		end_sim();
	end
	initial begin
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clk);
		rd(8'h89, 8'h07);
		rd(8'h0c, 8'h00);
		rd(8'h8c, 8'h00);
		rd(8'h00, 8'h00);
		rd(8'h09, 8'h00);
		wr(8'h9f, 8'h07);
		rd(8'h09, 8'h07);
		wr(8'h09, 8'h05);
		rd(8'h88, 8'hff);
		chk({5'h00, ctrl_pin_out}, 8'h05);
		wr(8'h8c, 8'h80);
		wr(8'h89, 8'h17);
		rd(8'h89, 8'h17);
		$display("test setup done");
		wr(8'h08, 8'ha5);
		rd(8'h89, 8'h57);
		m.rd(b);
		chk(b, 8'ha5);
		rd(8'h89, 8'h17);
		chk({7'h00, irq}, 8'h01);
		wr(8'h0c, 8'h80);
		rd(8'h0c, 8'h00);
		m.wr(8'h3c, 1'b0);
		rd(8'h89, 8'h97);
		chk({7'h00, irq}, 8'h01);
		rd(8'h08, 8'h3c);
		rd(8'h89, 8'h17);
		$display("test transfers done");
		m.wr(8'h11, 1'b0);
		m.wr(8'h22, 1'b0);
		rd(8'h89, 8'hb7);
		rd(8'h08, 8'h22);
		rd(8'h89, 8'h37);
		wr(8'h89, 8'h17);
		rd(8'h89, 8'h17);
		$display("test overrun done");
		wr(8'h0c, 8'h80);
		wr(8'h8c, 8'h00);
		m.wr(8'h55, 1'b1);
		rd(8'h89, 8'h17);
		rd(8'h0c, 8'h00);
		m.wr(8'h66, 1'b0);
		m.wr(8'h77, 1'b0);
		rd(8'h0c, 8'h80);
		chk({7'h00, irq}, 8'h00);
		wr(8'h8c, 8'h80);
		rd(8'h8c, 8'h80);
		chk({7'h00, irq}, 8'h01);
		wr(8'h08, 8'h5a);
		rd(8'h89, 8'hf7);
		wr(8'h89, 8'h27);
		rd(8'h89, 8'h27);
		$display("test irq and mode done");
		end_sim();
	end
endmodule : parallel_slave_byte_port_bench
`default_nettype wire
